// file: verilog/vcb_bank.sv
/*
  vcb_bank: a16 configuration register bank of a register-based switch
  module, with a24 window decode toward the relay register block.
  assumes a vme-style slave cycle on backplane pins (strobe held until
  acknowledged), a logical-address strap and a modid line.
*/
// Overview of operation
// [RULE1] a24 base from offset bits 15..8
// [RULE2] a24 decode, matrix block at offset 8000
// [RULE3] only five of thirty-two a16 slots answer
// [RULE4] every a16 register is a sixteen-bit word
// [RULE5] id bits 15..14 read register-based class 11
// [RULE6] id bits 13..12 read a16/a24 code 00
// [RULE7] id bits 11..0 fixed maker code
// [RULE8] write to offset 00 sets logical address
// [RULE9] device type bits 15..12 read 7
// [RULE10] device type bits 11..0 fixed model code
// [RULE11] host never writes device type register
// [RULE12] status bit 15 shows a24 enabled
// [RULE13] status bit 14 high when modid unselected
// [RULE14] status bit 3 high after initialisation
// [RULE15] status bit 2 always reads one
// [RULE16] status bits 1..0 echo control bits
// [RULE17] status reads fffc, bits 13..4 ones
// [RULE18] control bit 15 enables a24 registers
// [RULE19] host always writes sysfail inhibit zero
// [RULE20] control bit 0 holds device in reset
// [RULE21] offset register readable, written by manager
// [RULE22] only device-dependent slot 3e implemented
// [RULE23] a16 base is c000 or la shifted six
// [RULE24] a16 sixteen-bit only, a24 sixteen or thirty-two
// [RULE25] 3e bit1 readback select, bit0 coil disable
// [RULE26] unused a16 offsets ignore writes, reads harmless
`timescale 1ns/1ps
module vcb_bank
  import vcb_pkg::*;
#(
  parameter logic [11:0] MAKER_ID   = 12'h5a5, // arbitrary value
  parameter logic [11:0] MODEL_CODE = 12'h123  // arbitrary value
) (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  la_switch,
  input  wire logic        modid,
  input  wire logic        ds_n,
  input  wire logic        write_n,
  input  wire logic        lword_n,
  input  wire logic [5:0]  am,
  input  wire logic [23:1] addr,
  input  wire logic [31:0] data_in,
  output logic      [31:0] data_out,
  output logic             data_oe,
  output logic             dtack_n,
  output logic             berr_n,
  output logic             mtx_sel,
  output logic             mtx_write,
  output logic             mtx_lword,
  output logic      [14:1] mtx_addr,
  output logic      [31:0] mtx_wdata,
  input  wire logic [31:0] mtx_rdata,
  output logic             dev_reset,
  output logic             readback_sel,
  output logic             coil_disable
);
  localparam int unsigned SYNC_W = 73;

  typedef struct packed {
    vcb_state_type         st;
    logic                  la_loaded;
    logic [7:0]            la;
    logic                  a24_en;
    logic                  sysfail_inh;
    logic                  soft_rst;
    logic [15:0]           a24_ofs;
    logic [1:0]            mod_ctrl;
    logic [INIT_CNT_W-1:0] init_cnt;
    logic                  ready;
    logic                  ds_prev;
    logic                  mtx_is_write;
    logic [31:0]           data_out;
    logic                  data_oe;
    logic                  dtack_n;
    logic                  berr_n;
    logic                  mtx_sel;
    logic                  mtx_write;
    logic                  mtx_lword;
    logic [14:1]           mtx_addr;
    logic [31:0]           mtx_wdata;
    logic                  dev_reset;
  } vcb_regs_type;

  vcb_regs_type r;
  vcb_regs_type next_r;

  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_q;
  logic [SYNC_W-1:0] sync_idle;
  logic              s_ds_n;
  logic              s_write_n;
  logic              s_lword_n;
  logic [5:0]        s_am;
  logic [23:1]       s_addr;
  logic [31:0]       s_data;
  logic              s_modid;
  logic [7:0]        s_la;

  // every backplane level passes two flops before decode
  assign sync_raw  = {ds_n, write_n, lword_n, am, addr, data_in, modid, la_switch};
  assign sync_idle = {3'h7, {(SYNC_W - 3){1'b0}}};

  vcb_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .async_in    (sync_raw),
    .reset_value (sync_idle),
    .sync_out    (sync_q)
  );

  assign {s_ds_n, s_write_n, s_lword_n, s_am, s_addr, s_data, s_modid, s_la} = sync_q;

  logic        strobe_start;
  logic        is_a16;
  logic        is_a24;
  logic        a16_hit;
  logic        a24_hit;
  logic [5:0]  a16_ofs;
  logic        slot_impl;
  logic [15:0] word_rd;
  logic [15:0] wr16;

  always_comb begin
    next_r       = r;
    // strobe qualified by sync stage two and its own history
    strobe_start = !s_ds_n && r.ds_prev;
    is_a16       = (s_am == AM_A16_USER) || (s_am == AM_A16_SUPER);
    is_a24       = (s_am == AM_A24_USER) || (s_am == AM_A24_SUPER);
    a16_ofs      = {s_addr[5:1], 1'b0};
    wr16         = s_data[15:0];
    // c000 or la << 6
    a16_hit      = is_a16 && r.la_loaded && (s_addr[15:14] == A16_BASE_TOP)
                   && (s_addr[13:LA_SHIFT] == r.la); // [RULE23]
    // only base bits 23..16 compared, lower base bits are zero
    a24_hit      = is_a24 && r.a24_en
                   && (s_addr[23:16] == r.a24_ofs[15:16-A24_BASE_BITS]); // [RULE1]
    slot_impl    = (a16_ofs == OFS_IDENT) || (a16_ofs == OFS_DEVTYPE) || (a16_ofs == OFS_STATCTL)
                   || (a16_ofs == OFS_A24OFS) || (a16_ofs == OFS_MODCTL); // [RULE3] [RULE22]

    word_rd = 16'h0000;
    case (a16_ofs)
      OFS_IDENT: begin
        word_rd = {CLASS_REGISTER, SPACE_A16_A24, MAKER_ID}; // [RULE5] [RULE6] [RULE7]
      end
      OFS_DEVTYPE: begin
        word_rd = {REQMEM_A24_64K, MODEL_CODE}; // [RULE9] [RULE10]
      end
      OFS_STATCTL: begin
        word_rd[SC_A24_EN]   = r.a24_en; // [RULE12]
        word_rd[SC_MODID]    = !s_modid; // [RULE13]
        word_rd[13:4]        = SC_UNUSED; // [RULE17]
        word_rd[SC_READY]    = r.ready; // [RULE14]
        word_rd[SC_PASSED]   = 1'b1; // [RULE15]
        word_rd[SC_SYSF_INH] = r.sysfail_inh; // [RULE16]
        word_rd[SC_SOFT_RST] = r.soft_rst; // [RULE16]
      end
      OFS_A24OFS: begin
        word_rd = r.a24_ofs; // [RULE21]
      end
      OFS_MODCTL: begin
        word_rd = {14'h0000, r.mod_ctrl}; // [RULE25]
      end
      default: begin
        word_rd = 16'h0000;
      end
    endcase

    // strap caught once, after it has crossed both sync stages
    if (!r.la_loaded && (r.init_cnt == INIT_CNT_W'(LA_CAPTURE_CNT))) begin
      next_r.la        = s_la;
      next_r.la_loaded = 1'b1;
    end

    // init sequence restarts while soft reset is held
    if (r.soft_rst) begin
      next_r.init_cnt = '0;
      next_r.ready    = 1'b0;
    end else if (!r.ready) begin
      if (r.init_cnt == INIT_CNT_W'(INIT_CYCLES - 1)) begin
        next_r.ready = 1'b1; // [RULE14]
      end else begin
        next_r.init_cnt = r.init_cnt + INIT_CNT_W'(1);
      end
    end

    next_r.ds_prev = s_ds_n;
    next_r.mtx_sel = 1'b0;

    case (r.st)
      VCB_IDLE: begin
        if (strobe_start && a16_hit) begin
          if (!s_lword_n) begin
            next_r.berr_n = 1'b0; // [RULE24]
            next_r.st     = VCB_ACK;
          end else if (!slot_impl) begin
            // nothing answers here; the master times out
            next_r.st = VCB_IGNORE; // [RULE26]
          end else begin
            next_r.dtack_n = 1'b0;
            next_r.st      = VCB_ACK;
            if (s_write_n) begin
              next_r.data_out = {16'h0000, word_rd}; // [RULE4]
              next_r.data_oe  = 1'b1;
            end else begin
              case (a16_ofs)
                OFS_IDENT: begin
                  next_r.la = wr16[7:0]; // [RULE8]
                end
                OFS_STATCTL: begin
                  next_r.a24_en      = wr16[SC_A24_EN]; // [RULE18]
                  next_r.sysfail_inh = wr16[SC_SYSF_INH];
                  next_r.soft_rst    = wr16[SC_SOFT_RST]; // [RULE20]
                end
                OFS_A24OFS: begin
                  next_r.a24_ofs = wr16; // [RULE21]
                end
                OFS_MODCTL: begin
                  if (!r.soft_rst) begin
                    next_r.mod_ctrl = wr16[1:0]; // [RULE25]
                  end
                end
                default: begin
                  // device type write accepted and dropped
                  next_r.la = r.la; // [RULE11]
                end
              endcase
            end
          end
        end else if (strobe_start && a24_hit && (s_addr[15] == MTX_BLOCK_A15)) begin
          next_r.mtx_sel      = 1'b1; // [RULE2]
          next_r.mtx_write    = !s_write_n;
          next_r.mtx_is_write = !s_write_n;
          next_r.mtx_lword    = !s_lword_n; // [RULE24]
          next_r.mtx_addr     = s_addr[14:1];
          next_r.mtx_wdata    = s_data;
          next_r.st           = VCB_MTX_WAIT;
        end else if (strobe_start) begin
          next_r.st = VCB_IGNORE;
        end
      end
      VCB_MTX_WAIT: begin
        next_r.dtack_n = 1'b0;
        next_r.st      = VCB_ACK;
        if (!r.mtx_is_write) begin
          next_r.data_out = mtx_rdata;
          next_r.data_oe  = 1'b1;
        end
      end
      VCB_ACK, VCB_IGNORE: begin
        if (s_ds_n) begin
          next_r.dtack_n  = 1'b1;
          next_r.berr_n   = 1'b1;
          next_r.data_oe  = 1'b0;
          next_r.data_out = 32'h0000_0000;
          next_r.st       = VCB_IDLE;
        end
      end
      default: begin
        next_r.st = VCB_IDLE;
      end
    endcase

    // soft reset holds the operational side at power-on values
    if (next_r.soft_rst) begin
      next_r.mod_ctrl = MC_RESET; // [RULE20]
    end
    next_r.dev_reset = next_r.soft_rst; // [RULE20]
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      r              <= '0;
      r.st           <= VCB_IDLE;
      r.a24_ofs      <= A24OFS_RESET;
      r.mod_ctrl     <= MC_RESET;
      r.ds_prev      <= 1'b1;
      r.dtack_n      <= 1'b1;
      r.berr_n       <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign data_out     = r.data_out;
  assign data_oe      = r.data_oe;
  assign dtack_n      = r.dtack_n;
  assign berr_n       = r.berr_n;
  assign mtx_sel      = r.mtx_sel;
  assign mtx_write    = r.mtx_write;
  assign mtx_lword    = r.mtx_lword;
  assign mtx_addr     = r.mtx_addr;
  assign mtx_wdata    = r.mtx_wdata;
  assign dev_reset    = r.dev_reset;
  assign readback_sel = r.mod_ctrl[MC_READBACK];
  assign coil_disable = r.mod_ctrl[MC_COIL_DIS];
endmodule

// file: inc/vcb_pkg.sv
/*
  vcb_pkg: offsets, field positions, codes and timing constants of the
  configuration register bank.
  assumes a 10 MHz system clock and a backplane bus sampled on that clock.
*/
package vcb_pkg;
  // clock and power-on initialisation time
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned INIT_TIME_NS  = 10000;
  localparam int unsigned INIT_CYCLES   = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned INIT_CNT_W    = 8;
  // strap is through both sync stages by this count
  localparam int unsigned LA_CAPTURE_CNT = 2;

  // address modifiers: short (a16) and standard (a24) data access
  localparam logic [5:0] AM_A16_USER  = 6'h29;
  localparam logic [5:0] AM_A16_SUPER = 6'h2d;
  localparam logic [5:0] AM_A24_USER  = 6'h39;
  localparam logic [5:0] AM_A24_SUPER = 6'h3d;

  // a16 base: logical address shifted left six, ored with c000
  localparam logic [1:0] A16_BASE_TOP = 2'h3;
  localparam int unsigned LA_SHIFT    = 6;

  // a16 register byte offsets
  localparam logic [5:0] OFS_IDENT   = 6'h00;
  localparam logic [5:0] OFS_DEVTYPE = 6'h02;
  localparam logic [5:0] OFS_STATCTL = 6'h04;
  localparam logic [5:0] OFS_A24OFS  = 6'h06;
  localparam logic [5:0] OFS_MODCTL  = 6'h3e;

  // identification register fields
  localparam logic [1:0] CLASS_REGISTER = 2'h3;
  localparam logic [1:0] SPACE_A16_A24  = 2'h0;
  localparam logic [3:0] REQMEM_A24_64K = 4'h7;

  // status / control bit positions
  localparam int unsigned SC_A24_EN   = 15;
  localparam int unsigned SC_MODID    = 14;
  localparam int unsigned SC_READY    = 3;
  localparam int unsigned SC_PASSED   = 2;
  localparam int unsigned SC_SYSF_INH = 1;
  localparam int unsigned SC_SOFT_RST = 0;
  localparam logic [9:0]  SC_UNUSED   = 10'h3ff;

  // module control bit positions and reset values
  localparam int unsigned MC_READBACK = 1;
  localparam int unsigned MC_COIL_DIS = 0;
  localparam logic [1:0]  MC_RESET    = 2'h0;
  localparam logic [15:0] A24OFS_RESET = 16'h0000;

  // a24 window: offset bits 15..8 give a24 address bits 23..16
  localparam int unsigned A24_BASE_BITS = 8;
  localparam logic        MTX_BLOCK_A15 = 1'b1;

  typedef enum logic [1:0] {
    VCB_IDLE     = 2'b00,
    VCB_MTX_WAIT = 2'b01,
    VCB_ACK      = 2'b10,
    VCB_IGNORE   = 2'b11
  } vcb_state_type;
endpackage

// file: verilog/vcb_sync.sv
/*
  vcb_sync: two flip-flop synchroniser for a bus of backplane levels.
  assumes grouped bits are stable around their qualifying strobe.
*/
`timescale 1ns/1ps
module vcb_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] reset_value,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] q;
  } vcb_sync_type;

  vcb_sync_type r;
  vcb_sync_type next_r;

  // first stage feeds only the second
  always_comb begin
    next_r      = r;
    next_r.meta = async_in;
    next_r.q    = r.meta;
  end

  // idle levels at reset, so no false strobe edge after release
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      r.meta <= reset_value;
      r.q    <= reset_value;
    end else begin
      r <= next_r;
    end
  end

  assign sync_out = r.q;
endmodule

// file: testbench/vcb_bank_asserts.sv
/*
  vcb_bank_chk: port-level checks of the register bank.
  assumes it is bound to vcb_bank as below.
*/
`timescale 1ns/1ps
module vcb_bank_chk
  import vcb_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic [5:0]  am,
  input wire logic [23:1] addr,
  input wire logic [31:0] data_out,
  input wire logic        data_oe,
  input wire logic        dtack_n,
  input wire logic        berr_n,
  input wire logic        mtx_sel,
  input wire logic [14:1] mtx_addr,
  input wire logic        dev_reset,
  input wire logic        readback_sel,
  input wire logic        coil_disable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire logic a16 = am == AM_A16_USER || am == AM_A16_SUPER;

  ack_excl_a: assert property (!berr_n |-> dtack_n) else $error("berr with dtack");
  ack_hold_a: assert property ($fell(dtack_n) |-> !dtack_n [*3]) else $error("dtack too short");
  oe_ack_a: assert property (data_oe |-> !dtack_n) else $error("data without dtack");
  idle_zero_a: assert property (!data_oe |-> data_out == 32'h0) else $error("idle data");
  word_a16_a: assert property (data_oe && a16 |-> data_out[31:16] == 16'h0) else $error("a16 upper");
  id_class_a: assert property (data_oe && a16 && addr[5:1] == 5'h0 |-> data_out[15:12] == 4'hc)
    else $error("id class");
  stat_fix_a: assert property (data_oe && a16 && addr[5:1] == 5'h2
    |-> data_out[13:4] == 10'h3ff && data_out[2]) else $error("status fixed bits");
  mtx_pulse_a: assert property (mtx_sel |=> !mtx_sel && !dtack_n) else $error("matrix pulse");
  mtx_addr_a: assert property (mtx_sel |-> addr[15] && !a16 && mtx_addr == addr[14:1])
    else $error("matrix address");
  rst_idle_a: assert property ($rose(resetn) |-> dtack_n && berr_n && !data_oe) else $error("reset idle");
  soft_clr_a: assert property (dev_reset |=> !readback_sel && !coil_disable) else $error("soft reset");
endmodule

bind vcb_bank vcb_bank_chk i_chk (
  .sys_clk      (sys_clk),
  .resetn       (resetn),
  .am           (am),
  .addr         (addr),
  .data_out     (data_out),
  .data_oe      (data_oe),
  .dtack_n      (dtack_n),
  .berr_n       (berr_n),
  .mtx_sel      (mtx_sel),
  .mtx_addr     (mtx_addr),
  .dev_reset    (dev_reset),
  .readback_sel (readback_sel),
  .coil_disable (coil_disable)
);

// file: testbench/vcb_mtx_model.sv
/*
  vcb_mtx_model: relay register block behind the a24 window.
  assumes mtx_rdata is sampled the cycle after mtx_sel.
*/
`timescale 1ns/1ps
module vcb_mtx_model (
  input  wire logic        sys_clk,
  input  wire logic        mtx_sel,
  input  wire logic        mtx_write,
  input  wire logic [31:0] mtx_wdata,
  output logic      [31:0] mtx_rdata
);
  logic [31:0] relays;
  // whole 32-bit word kept, both relay registers at once
  always_ff @(posedge sys_clk) begin
    if (mtx_sel && mtx_write) relays <= mtx_wdata;
  end
  assign mtx_rdata = relays;
endmodule

// file: testbench/vcb_bank_tb.sv
/*
  vcb_bank_tb: register-level tests of the bank over the backplane cycle.
  assumes strap la 05 and the default identity parameters.
*/
`timescale 1ns/1ps
module vcb_bank_tb import vcb_pkg::*; ;
  logic        sys_clk = 1'b0, resetn = 1'b0, modid = 1'b0, ds_n = 1'b1, write_n = 1'b1, lword_n = 1'b1;
  logic [7:0]  la_switch = 8'h05;
  logic [5:0]  am = 6'h00;
  logic [23:1] addr = 23'h0;
  logic [31:0] data_in = 32'h0, data_out, mtx_wdata, mtx_rdata, rd;
  logic        data_oe, dtack_n, berr_n, mtx_sel, mtx_write, mtx_lword, dev_reset, readback_sel, coil_disable;
  logic [14:1] mtx_addr;
  logic [15:0] base = 16'hc140;
  logic [1:0]  ok;
  int          failures = 0, checks_done = 0, i;

  vcb_bank i_dut (
    .sys_clk      (sys_clk),
    .resetn       (resetn),
    .la_switch    (la_switch),
    .modid        (modid),
    .ds_n         (ds_n),
    .write_n      (write_n),
    .lword_n      (lword_n),
    .am           (am),
    .addr         (addr),
    .data_in      (data_in),
    .data_out     (data_out),
    .data_oe      (data_oe),
    .dtack_n      (dtack_n),
    .berr_n       (berr_n),
    .mtx_sel      (mtx_sel),
    .mtx_write    (mtx_write),
    .mtx_lword    (mtx_lword),
    .mtx_addr     (mtx_addr),
    .mtx_wdata    (mtx_wdata),
    .mtx_rdata    (mtx_rdata),
    .dev_reset    (dev_reset),
    .readback_sel (readback_sel),
    .coil_disable (coil_disable)
  );
  vcb_mtx_model i_mtx (
    .sys_clk   (sys_clk),
    .mtx_sel   (mtx_sel),
    .mtx_write (mtx_write),
    .mtx_wdata (mtx_wdata),
    .mtx_rdata (mtx_rdata)
  );

  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ok: 1 dtack, 2 berr, 0 no answer (master times out)
  task automatic acc(input logic w, input logic [5:0] m, input logic [23:0] a, input logic [31:0] d,
                     input logic lw = 1'b1);
    int n;
    @(posedge sys_clk);
    am <= m;
    addr <= a[23:1];
    data_in <= d;
    write_n <= !w;
    lword_n <= lw;
    ok = 2'd0;
    repeat (2) @(posedge sys_clk);
    ds_n <= 1'b0;
    for (n = 0; n < 12 && ok == 2'd0; n++) begin
      @(posedge sys_clk);
      if (dtack_n === 1'b0) ok = 2'd1;
      else if (berr_n === 1'b0) ok = 2'd2;
    end
    rd = data_out;
    ds_n <= 1'b1;
    for (n = 0; n < 12 && (dtack_n !== 1'b1 || berr_n !== 1'b1); n++) @(posedge sys_clk);
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic final_report;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    // read before the ready delay has run out
    acc(1'b0, AM_A16_USER, {8'h0, base | 16'h4}, 32'h0);
    chk("stat_early", 32'h7ff4, rd);
    repeat (100) @(posedge sys_clk);
    acc(1'b0, AM_A16_USER, {8'h0, base | 16'h4}, 32'h0);
    chk("stat_ready", 32'h7ffc, rd);
    acc(1'b0, AM_A16_USER, {8'h0, base}, 32'h0);
    chk("ident", 32'hc5a5, rd);
    // device type is only ever read here
    acc(1'b0, AM_A16_SUPER, {8'h0, base | 16'h2}, 32'h0);
    chk("devtype", 32'h7123, rd);
    acc(1'b0, AM_A24_USER, 24'h008004, 32'h0);
    chk("a24_off", 32'h0, {30'h0, ok});
    acc(1'b1, AM_A16_USER, {8'h0, base | 16'h4}, 32'h8000);
    acc(1'b0, AM_A16_USER, {8'h0, base | 16'h4}, 32'h0);
    chk("stat_en", 32'hfffc, rd);
    modid <= 1'b1;
    acc(1'b0, AM_A16_USER, {8'h0, base | 16'h4}, 32'h0);
    chk("stat_sel", 32'hbffc, rd);
    modid <= 1'b0;
    acc(1'b1, AM_A16_USER, {8'h0, base | 16'h6}, 32'h2a00);
    acc(1'b0, AM_A16_USER, {8'h0, base | 16'h6}, 32'h0);
    chk("offset", 32'h2a00, rd);
    acc(1'b1, AM_A24_USER, 24'h2a8004, 32'h12345678, 1'b0);
    chk("a24_wr", 32'h1, {30'h0, ok});
    chk("mtx_addr", 32'h2, {18'h0, mtx_addr});
    chk("mtx_wdata", 32'h12345678, mtx_wdata);
    chk("mtx_lword", 32'h1, {31'h0, mtx_lword});
    acc(1'b0, AM_A24_SUPER, 24'h2a8004, 32'h0, 1'b0);
    chk("a24_rd", 32'h12345678, rd);
    acc(1'b0, AM_A24_USER, 24'h2a8006, 32'h0);
    chk("a24_16", 32'h1, {30'h0, ok});
    chk("mtx_lw16", 32'h0, {31'h0, mtx_lword});
    chk("mtx_addr16", 32'h3, {18'h0, mtx_addr});
    acc(1'b0, AM_A24_USER, 24'h2a0004, 32'h0);
    chk("a24_low", 32'h0, {30'h0, ok});
    acc(1'b0, AM_A24_USER, 24'h2b8004, 32'h0);
    chk("a24_out", 32'h0, {30'h0, ok});
    acc(1'b0, AM_A16_USER, {8'h0, base}, 32'h0, 1'b0);
    chk("a16_long", 32'h2, {30'h0, ok});
    acc(1'b1, AM_A16_USER, {8'h0, base | 16'h3e}, 32'h3);
    acc(1'b0, AM_A16_USER, {8'h0, base | 16'h3e}, 32'h0);
    chk("modctl", 32'h3, rd);
    chk("modpins", 32'h3, {30'h0, readback_sel, coil_disable});
    for (i = 8; i < 62; i += 2) begin
      acc(1'b1, AM_A16_USER, {8'h0, base | i[15:0]}, 32'hffff);
      chk("unused_wr", 32'h0, {30'h0, ok});
      acc(1'b0, AM_A16_USER, {8'h0, base | i[15:0]}, 32'h0);
      chk("unused_rd", 32'h0, {30'h0, ok});
    end
    acc(1'b0, AM_A16_USER, {8'h0, base | 16'h6}, 32'h0);
    chk("offset_kept", 32'h2a00, rd);
    acc(1'b1, AM_A16_USER, {8'h0, base | 16'h4}, 32'h8001);
    chk("devrst_on", 32'h1, {31'h0, dev_reset});
    acc(1'b0, AM_A16_USER, {8'h0, base | 16'h4}, 32'h0);
    chk("stat_echo", 32'h1, {30'h0, rd[1:0]});
    acc(1'b0, AM_A16_USER, {8'h0, base | 16'h3e}, 32'h0);
    chk("modctl_rst", 32'h0, rd);
    acc(1'b1, AM_A16_USER, {8'h0, base | 16'h4}, 32'h8000);
    chk("devrst_off", 32'h0, {31'h0, dev_reset});
    acc(1'b1, AM_A16_USER, {8'h0, base}, 32'h7);
    acc(1'b0, AM_A16_USER, {8'h0, 16'hc1c0}, 32'h0);
    chk("la_new", 32'hc5a5, rd);
    acc(1'b0, AM_A16_USER, {8'h0, base}, 32'h0);
    chk("la_old", 32'h0, {30'h0, ok});
    final_report;
  end

  // tests take about 1500 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    final_report;
  end
endmodule
